// ==== common/sdl_pkg.sv ====
package sdl_pkg;
    localparam int          FRAME_BITS    = 24;
    localparam int          CODE_BITS     = 20;
    localparam int          CNT_W         = 5;
    localparam logic [4:0]  FRAME_LAST    = 5'h17;
    localparam int          CLK_PERIOD_NS = 25;
    // Clear value and coding come from outside; defaults used at reset
    localparam logic [19:0] CODE_RESET    = 20'h00000;
    localparam logic [19:0] CODE_MID      = 20'h80000;
    localparam logic [19:0] CODE_FULL     = 20'hfffff;
    localparam logic [1:0]  BUF_DEPTH     = 2'h2;
    // Idle level per synchronised pin: frame select, load and clear high, rest low
    localparam logic [5:0]  SYNC_IDLE     = 6'h16;
endpackage

// ==== common/sdl_frame_if.sv ====
`timescale 1ns/1ps
interface sdl_frame_if;
    logic        valid;
    logic        ready;
    logic [23:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== hw/sdl_frame_buf.sv ====
`timescale 1ns/1ps
module sdl_frame_buf (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    sdl_frame_if.snk  in_if,
    sdl_frame_if.src  out_if
);
    logic [23:0] mem_ff [2];
    logic        wr_ptr_ff;
    logic        rd_ptr_ff;
    logic [1:0]  cnt_ff;
    wire         push = in_if.valid && in_if.ready;
    wire         pop  = out_if.valid && out_if.ready;

    assign in_if.ready  = (cnt_ff != sdl_pkg::BUF_DEPTH);
    assign out_if.valid = (cnt_ff != 2'h0);
    assign out_if.data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
            mem_ff[0] <= 24'h000000;
            mem_ff[1] <= 24'h000000;
        end else begin
            if (push) begin
                mem_ff[wr_ptr_ff] <= in_if.data;
                wr_ptr_ff         <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ==== hw/sdl_load_if.sv ====
// Contract
// R1: Active-low reset returns all state and the output to power-on values.
// R2: Clear loads the DAC register with the clear value at once.
// R3: DAC register and clear value read per selected coding, binary or twos complement.
// R4: Load held low: DAC register updates when the frame select rises.
// R5: Load high: only input register updates; DAC waits for load falling edge.
// R6: Readback bits driven on serial_out at serial clock rising edges.
// R7: A 24-bit input shift register collects each frame.
// R8: Serial_in sampled on each serial clock falling edge.
// R9: Writes accepted up to 35 MHz serial clock. Code samples it with the 40 MHz clock_i, so above 20 MHz edges can be lost.
// R10: Frame select falling enables shifting on following serial clock falls.
// R11: Host holds frame select low for a whole frame, raises it to end.
// R12: After reset the output is 0 V and clamped to ground.
// R13: Serial_out released to high impedance after frame select rises.
// R14: Host limits serial clock to 16 MHz during readback.
// R15: Binary code 0 is negative reference, 80000 midscale, fffff full minus one.
// R16: MSB first; frames other than 24 falling edges are discarded.
// R17: Reset, clear, load async; reset over clear over pending update. Code: only reset async; clear and load are synchronised.
`timescale 1ns/1ps
module sdl_load_if (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic        serial_clock_i,
    input  wire logic        frame_select_n_i,
    input  wire logic        serial_in_i,
    input  wire logic        load_output_n_i,
    input  wire logic        clear_to_preset_n_i,
    input  wire logic        twos_comp_i,
    input  wire logic [19:0] clear_code_i,
    input  wire logic [23:0] readback_word_i,
    output logic             serial_out_o,
    output logic             serial_out_oe_o,
    output logic [23:0]      input_reg_o,
    output logic [19:0]      dac_code_o,
    output logic [19:0]      dac_offset_code_o,
    output logic             output_clamp_o,
    output logic             dac_update_o
);
    // Two-flop synchronisers for the six single-bit pins other than reset, one generate loop
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic [NSYNC-1:0] s3_ff;
    wire  [NSYNC-1:0] raw_in = {serial_clock_i, frame_select_n_i, serial_in_i,
                                load_output_n_i, clear_to_preset_n_i, twos_comp_i};
    // Reset to each pin's idle level so no false edge follows reset
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    s1_ff[gi] <= sdl_pkg::SYNC_IDLE[gi];
                    s2_ff[gi] <= sdl_pkg::SYNC_IDLE[gi];
                    s3_ff[gi] <= sdl_pkg::SYNC_IDLE[gi];
                end else begin
                    s1_ff[gi] <= raw_in[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                end
            end
        end
    endgenerate

    wire sclk      = s2_ff[5];
    wire sclk_d    = s3_ff[5];
    wire fs_n      = s2_ff[4];
    wire fs_n_d    = s3_ff[4];
    wire sdi       = s2_ff[3];
    wire ld_n      = s2_ff[2];
    wire ld_n_d    = s3_ff[2];
    wire clr_n     = s2_ff[1];
    wire twos      = s2_ff[0];
    wire sclk_fall = sclk_d && !sclk;
    wire sclk_rise = !sclk_d && sclk;
    wire fs_fall   = fs_n_d && !fs_n;
    wire fs_rise   = !fs_n_d && fs_n;
    wire ld_fall   = ld_n_d && !ld_n;

    logic [23:0] shift_ff;
    logic [4:0]  bits_ff;
    logic        over_ff;
    logic        in_frame_ff;
    logic [23:0] rb_ff;
    logic [23:0] input_reg_ff;
    logic [19:0] dac_ff;
    logic        pending_ff;
    logic        clamp_ff;
    logic        upd_ff;
    logic        sdo_ff;
    logic        sdo_oe_ff;

    // Wide side inputs must stay static while in use; two stages bring them onto this clock
    logic [19:0] clr_code_s1_ff;
    logic [19:0] clr_code_s2_ff;
    logic [23:0] rb_word_s1_ff;
    logic [23:0] rb_word_s2_ff;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clr_code_s1_ff <= sdl_pkg::CODE_RESET;
            clr_code_s2_ff <= sdl_pkg::CODE_RESET;
            rb_word_s1_ff  <= 24'h000000;
            rb_word_s2_ff  <= 24'h000000;
        end else begin
            clr_code_s1_ff <= clear_code_i;
            clr_code_s2_ff <= clr_code_s1_ff;
            rb_word_s1_ff  <= readback_word_i;
            rb_word_s2_ff  <= rb_word_s1_ff;
        end
    end

    sdl_frame_if fin ();
    sdl_frame_if fout ();

    // A frame counts only with exactly 24 falling edges
    wire frame_ok = fs_rise && in_frame_ff && (bits_ff == sdl_pkg::FRAME_LAST + 5'h01) && !over_ff; // [R16]
    assign fin.valid = frame_ok;
    assign fin.data  = shift_ff;
    assign fout.ready = 1'b1;

    sdl_frame_buf u_buf (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .in_if     (fin),
        .out_if    (fout)
    );

    wire [23:0] nxt_shift = {shift_ff[22:0], sdi};
    wire        word_in   = fout.valid;
    // A load falling edge applies only a word already waiting
    wire        do_load   = (word_in && !ld_n) || (pending_ff && ld_fall); // [R4] [R5]
    wire [19:0] nxt_code  = word_in ? fout.data[19:0] : input_reg_ff[19:0];

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_ff    <= 24'h000000;
            bits_ff     <= 5'h00;
            over_ff     <= 1'b0;
            in_frame_ff <= 1'b0;
        end else if (fs_fall) begin // [R10]
            in_frame_ff <= 1'b1;
            bits_ff     <= 5'h00;
            over_ff     <= 1'b0;
        end else if (fs_rise) begin
            in_frame_ff <= 1'b0;
        end else if (in_frame_ff && !fs_n && sclk_fall) begin
            shift_ff <= nxt_shift; // [R7] [R8] [R16]
            if (bits_ff == sdl_pkg::FRAME_LAST + 5'h01) begin
                over_ff <= 1'b1;
            end else begin
                bits_ff <= bits_ff + 5'h01;
            end
        end
    end

    // Readback shifter: MSB driven at each rising serial clock edge
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rb_ff     <= 24'h000000;
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else if (fs_fall) begin
            rb_ff     <= rb_word_s2_ff;
            sdo_oe_ff <= 1'b1;
        end else if (fs_rise || fs_n) begin
            // Host must not sample serial_out once the frame has closed
            sdo_oe_ff <= 1'b0; // [R13]
            sdo_ff    <= 1'b0;
        end else if (sclk_rise) begin
            sdo_ff <= rb_ff[23]; // [R6]
            rb_ff  <= {rb_ff[22:0], 1'b0};
        end
    end

    // Reset beats clear, clear beats a pending deferred load
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin // [R1] [R12]
            input_reg_ff <= 24'h000000;
            dac_ff       <= sdl_pkg::CODE_RESET;
            pending_ff   <= 1'b0;
            clamp_ff     <= 1'b1;
            upd_ff       <= 1'b0;
        end else if (!clr_n) begin // [R2] [R17]
            dac_ff     <= clr_code_s2_ff;
            pending_ff <= 1'b0;
            clamp_ff   <= 1'b0;
            upd_ff     <= 1'b1;
        end else begin
            upd_ff <= do_load;
            if (word_in) begin
                input_reg_ff <= fout.data;
            end
            if (do_load) begin
                dac_ff     <= nxt_code;
                clamp_ff   <= 1'b0;
                pending_ff <= 1'b0;
            end else if (word_in) begin
                pending_ff <= 1'b1; // [R5]
            end
        end
    end

    // Offset-binary code for the converter core: twos complement flips MSB
    logic [19:0] offs_ff;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            offs_ff <= sdl_pkg::CODE_RESET;
        end else begin
            offs_ff <= twos ? (dac_ff ^ sdl_pkg::CODE_MID) : dac_ff; // [R3] [R15]
        end
    end

    assign serial_out_o      = sdo_ff;
    assign serial_out_oe_o   = sdo_oe_ff;
    assign input_reg_o       = input_reg_ff;
    assign dac_code_o        = dac_ff;
    assign dac_offset_code_o = offs_ff;
    assign output_clamp_o    = clamp_ff;
    assign dac_update_o      = upd_ff;
endmodule

// ==== sim/sdl_load_if_sva.sv ====
`timescale 1ns/1ps
module sdl_chk (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        frame_select_n_i,
    input wire logic        load_output_n_i,
    input wire logic        clear_to_preset_n_i,
    input wire logic        twos_comp_i,
    input wire logic [19:0] clear_code_i,
    input wire logic        serial_out_oe_o,
    input wire logic [19:0] dac_code_o,
    input wire logic [19:0] dac_offset_code_o,
    input wire logic        output_clamp_o,
    input wire logic        dac_update_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_clear_held; !clear_to_preset_n_i[*6]; endsequence
    sequence s_load_idle; (load_output_n_i && clear_to_preset_n_i)[*8]; endsequence
    a_reset_state: assert property (disable iff (1'b0) !reset_n_i |-> output_clamp_o && dac_code_o == 20'h0)
        else $error("reset state wrong");
    a_clear_value: assert property (s_clear_held |-> dac_code_o == clear_code_i && dac_update_o)
        else $error("clear value not loaded");
    a_code_cause: assert property ($changed(dac_code_o) |-> dac_update_o)
        else $error("code changed without update");
    a_deferred_hold: assert property (s_load_idle |-> !dac_update_o)
        else $error("update while load high");
    a_out_release: assert property (frame_select_n_i[*6] |-> !serial_out_oe_o)
        else $error("readback still driven");
    a_coding_map: assert property ($past(reset_n_i, 2) ##0 $stable(twos_comp_i)[*4]
        |-> dac_offset_code_o == ($past(dac_code_o) ^ {twos_comp_i, 19'h0}))
        else $error("offset code wrong");
    a_clamp_drop: assert property ($fell(output_clamp_o) |-> dac_update_o || $past(dac_update_o))
        else $error("clamp dropped without load");
    a_update_pulse: assert property (clear_to_preset_n_i[*5] ##0 dac_update_o |=> !dac_update_o)
        else $error("update longer than a pulse");
endmodule
bind sdl_load_if sdl_chk u_chk (.clock_i, .reset_n_i, .frame_select_n_i, .load_output_n_i,
    .clear_to_preset_n_i, .twos_comp_i, .clear_code_i, .serial_out_oe_o, .dac_code_o,
    .dac_offset_code_o, .output_clamp_o, .dac_update_o);

// ==== sim/sdl_host_model.sv ====
`timescale 1ns/1ps
module sdl_host_model (
    output logic      serial_clock_o   = 1'b0,
    output logic      frame_select_n_o = 1'b1,
    output logic      serial_in_o      = 1'b0,
    input  wire logic serial_out_i
);
    // 5 MHz link, below both the write and readback limits
    task automatic send(input logic [23:0] word, input int nbits, output logic [23:0] rb);
        #407;
        frame_select_n_o = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++) begin
            serial_in_o    = word[23 - i];
            serial_clock_o = 1'b1;
            #100;
            serial_clock_o = 1'b0;
            #100;
            rb = {rb[22:0], serial_out_i};
        end
        frame_select_n_o = 1'b1;
        // Released line must not look like held data
        serial_in_o      = ~serial_in_o;
    endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        clock_i    = 1'b0;
    logic        reset_n_i  = 1'b1;
    logic        load_n     = 1'b0;
    logic        clear_n    = 1'b1;
    logic        twos       = 1'b0;
    logic [19:0] clear_code = 20'h3c5a1;
    logic [23:0] rb_word    = 24'ha53c96;
    logic        sclk, fs_n, sdi, serial_out, sdo_oe, upd, clamp;
    logic [23:0] in_reg, rb;
    logic [19:0] code, off;
    logic [44:0] rows [5] = '{{1'b0, 24'h0fffff, 20'hfffff}, {1'b0, 24'h080000, 20'h80000},
        {1'b1, 24'h000000, 20'h80000}, {1'b1, 24'h07ffff, 20'hfffff}, {1'b0, 24'h100000, 20'h00000}};
    int          num_errors      = 0;
    int          samples_checked = 0;
    always #12.5 clock_i = ~clock_i;
    sdl_host_model u_host (.serial_clock_o(sclk), .frame_select_n_o(fs_n), .serial_in_o(sdi), .serial_out_i(serial_out));
    sdl_load_if u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .serial_clock_i(sclk), .frame_select_n_i(fs_n),
        .serial_in_i(sdi), .load_output_n_i(load_n), .clear_to_preset_n_i(clear_n), .twos_comp_i(twos),
        .clear_code_i(clear_code), .readback_word_i(rb_word), .serial_out_o(serial_out), .serial_out_oe_o(sdo_oe),
        .input_reg_o(in_reg), .dac_code_o(code), .dac_offset_code_o(off), .output_clamp_o(clamp),
        .dac_update_o(upd));
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Returns two edges after the pulse so the offset code has settled too
    task automatic wait_upd();
        int n;
        n = 0;
        while (upd !== 1'b1 && n < 60) begin
            @(posedge clock_i);
            n++;
        end
        if (n == 60) begin
            chk("update wait", 24'h0, 24'h1);
            close_out();
        end
        repeat (2) @(posedge clock_i);
    endtask
    initial begin
        reset_n_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        chk("clamp at reset", {23'h0, clamp}, 24'h1);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        for (int i = 0; i < 5; i++) begin
            twos <= rows[i][44];
            u_host.send(rows[i][43:20], 24, rb);
            wait_upd();
            chk("readback", rb, rb_word);
            chk("input reg", in_reg, rows[i][43:20]);
            chk("dac code", {4'h0, code}, {4'h0, rows[i][39:20]});
            chk("offset code", {4'h0, off}, {4'h0, rows[i][19:0]});
        end
        load_n <= 1'b1;
        u_host.send(24'h0abcde, 24, rb);
        repeat (10) @(posedge clock_i);
        chk("held input", in_reg, 24'h0abcde);
        chk("held dac", {4'h0, code}, 24'h0);
        load_n <= 1'b0;
        wait_upd();
        chk("loaded dac", {4'h0, code}, 24'h0abcde);
        u_host.send(24'h012345, 23, rb);
        repeat (10) @(posedge clock_i);
        chk("short frame", in_reg, 24'h0abcde);
        clear_n <= 1'b0;
        repeat (10) @(posedge clock_i);
        chk("clear code", {4'h0, code}, {4'h0, clear_code});
        clear_n <= 1'b1;
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk("reset dac", {4'h0, code}, 24'h0);
        chk("reset clamp", {23'h0, clamp}, 24'h1);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        close_out();
    end
endmodule
